/* src/apmc_map.vh */
// Constants for the converter power-mode controller: register map,
// field positions, power states and timing.
// Assumes a 40 MHz core clock and a 32-bit APB register bus.
`ifndef APMC_MAP_VH
`define APMC_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define APMC_CTRL_ADDR      12'h000
`define APMC_STATUS_ADDR    12'h004
`define APMC_RESULT_ADDR    12'h008

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define APMC_CTRL_SEL_LO    0
`define APMC_CTRL_SEL_HI    1
`define APMC_CTRL_START     2
`define APMC_CTRL_CAL       3
`define APMC_CTRL_RESET     4'h0

////////////////////////////////////////////////////////////////////////////////
// Power states
`define APMC_ST_UP          3'h0
`define APMC_ST_FULLDOWN    3'h1
`define APMC_ST_PARTDOWN    3'h2
`define APMC_ST_WAKING      3'h3
`define APMC_ST_CONVERT     3'h4

////////////////////////////////////////////////////////////////////////////////
// Select codes
`define APMC_SEL_PIN        2'h0
`define APMC_SEL_NORMAL     2'h1
`define APMC_SEL_FULLDOWN   2'h2
`define APMC_SEL_PARTIAL    2'h3

////////////////////////////////////////////////////////////////////////////////
// Timing
`define APMC_CLK_MHZ        40
`define APMC_WAKE_US        5
`define APMC_WAKE_CYCLES    (`APMC_WAKE_US * `APMC_CLK_MHZ)
`define APMC_CONV_CYCLES    20
`define APMC_RES_BITS       14

`endif

/* src/apmc_pin_sync.v */
// Three-stage synchroniser for a level arriving from a pin.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
module apmc_pin_sync (
   core_clk,
   sys_rst,
   pinIn,
   pinLevel
);
   input  wire core_clk;   // Core clock
   input  wire sys_rst;    // Synchronous reset
   input  wire pinIn;      // Raw pin
   output reg  pinLevel;   // Filtered level

   parameter RESET_LEVEL = 1'b1;

   reg stage1;             // First stage, read by stage2 only
   reg stage2;             // Second stage
   reg stage3;             // Third stage

   ////////////////////////////////////////////////////////////////////////////
   // Shift chain; level changes once stages two and three agree
   always @(posedge core_clk) begin
      if (sys_rst) begin
         stage1   <= RESET_LEVEL;
         stage2   <= RESET_LEVEL;
         stage3   <= RESET_LEVEL;
         pinLevel <= RESET_LEVEL;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            pinLevel <= stage3;
         end
      end
   end
endmodule

/* src/apmc_wait_timer.v */
// Down-counter that flags when a loaded wait has run out.
// Assumes load and count values from the same clock domain.
`timescale 1ns/1ps
module apmc_wait_timer (
   core_clk,
   sys_rst,
   load,
   loadValue,
   expired
);
   parameter WIDTH = 12;

   input  wire             core_clk;   // Core clock
   input  wire             sys_rst;    // Synchronous reset
   input  wire             load;       // Start a new wait
   input  wire [WIDTH-1:0] loadValue;  // Cycles to wait
   output wire             expired;    // Count is zero

   reg [WIDTH-1:0] count;              // Remaining cycles

   assign expired = (count == {WIDTH{1'b0}});

   ////////////////////////////////////////////////////////////////////////////
   // Load or count down to zero
   always @(posedge core_clk) begin
      if (sys_rst) begin
         count <= {WIDTH{1'b0}};
      end else if (load) begin
         count <= loadValue;
      end else if (!expired) begin
         count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* src/apmc_power_ctrl.v */
// Power-mode controller for a 14-bit successive-approximation converter.
// Holds the control, status and result registers, the power-state machine
// and the supply enables for the converter core and its reference.
// Assumes an APB master on core_clk and asynchronous sleep/start pins.
// Assumes the host keeps the select bits at zero while it uses the pin.
//
// The placing of the registers and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "apmc_map.vh"
module apmc_power_ctrl (
   core_clk,
   sys_rst,
   psel,
   penable,
   pwrite,
   paddr,
   pwdata,
   prdata,
   pready,
   pslverr,
   sleepPin_n,
   conversion_start_n,
   sampleCode,
   coreEnable,
   referenceEnable,
   busy,
   powerState
);
   parameter WAKE_CYCLES = `APMC_WAKE_CYCLES;   // Wake time in core cycles
   parameter CONV_CYCLES = `APMC_CONV_CYCLES;   // Conversion length in core cycles
   parameter RES_BITS    = `APMC_RES_BITS;      // Converter resolution

   // The state leaves one edge after the timer reaches zero, so a conversion
   // loads one less and busy stands for exactly CONV_CYCLES
   localparam integer CONV_LAST = CONV_CYCLES - 1;

   // Clock and reset
   input  wire                core_clk;            // 40 MHz core clock
   input  wire                sys_rst;             // Synchronous reset
   // APB slave
   input  wire                psel;                // APB select
   input  wire                penable;             // APB access phase
   input  wire                pwrite;              // APB direction
   input  wire [11:0]         paddr;               // APB byte address
   input  wire [31:0]         pwdata;              // APB write data
   output reg  [31:0]         prdata;              // APB read data
   output wire                pready;              // APB ready
   output wire                pslverr;             // APB error
   // Host pins, raw code in, supply enables and state out
   input  wire                sleepPin_n;          // External power-down pin
   input  wire                conversion_start_n;  // External conversion start
   input  wire [RES_BITS-1:0] sampleCode;          // Raw converter code
   output reg                 coreEnable;          // Converter circuitry on
   output reg                 referenceEnable;     // Reference on
   output reg                 busy;                // Conversion in progress
   output reg  [2:0]          powerState;          // Current power state

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   // Control register bits
   reg                power_select_high;   // Upper select bit
   reg                power_select_low;    // Lower select bit
   reg                swStart;             // Software start request
   reg                calRequest;          // Calibration request bit
   // Result, state and timer
   reg [RES_BITS-1:0] result;              // Latched result
   reg [2:0]          next_powerState;     // Next state
   reg                startPrev;           // Start pin last cycle
   reg                timerLoad;           // Load the shared timer
   reg [11:0]         timerValue;          // Value to load
   // Synchronised pins and decode
   wire               sleepLevel;          // Synchronised power-down pin
   wire               startLevel;          // Synchronised start pin
   wire               timerDone;           // Timer ran out
   wire               wrAccess;            // APB write this edge
   wire               rdSetup;             // APB read setup
   wire [1:0]         powerSelect;         // Combined select bits
   wire               startFall;           // Start pin fell
   wire               startRise;           // Start pin rose
   wire               convRequest;         // Any start request
   wire               busyFall;            // Conversion finished

   // Bus decode; the slave never stalls and never reports an error
   assign powerSelect = {power_select_high, power_select_low};
   assign pready      = 1'b1;
   assign pslverr     = 1'b0;
   // Writes land at the access edge; reads load data at the setup edge
   assign wrAccess    = psel & penable & pwrite;
   assign rdSetup     = psel & ~penable & ~pwrite;
   // Edges of the synchronised start pin; fall wakes, rise converts
   assign startFall   = startPrev & ~startLevel;
   assign startRise   = ~startPrev & startLevel;
   assign convRequest = startRise | swStart;

   // Address decode: true for the three mapped registers; reads of any
   // other offset return zero and writes there change nothing
   function known;
      input [11:0] addr;
      begin
         known = (addr == `APMC_CTRL_ADDR) | (addr == `APMC_STATUS_ADDR)
               | (addr == `APMC_RESULT_ADDR);
      end
   endfunction

   // Select bits with the pin decide whether the idle state is powered
   // 00 follows the pin, 01 stays up, 10 forces full down, 11 partial
   function [2:0] idleState;
      input [1:0] sel;
      input       pinHigh;
      begin
         case (sel)
            `APMC_SEL_PIN:      idleState = pinHigh ? `APMC_ST_UP
                                                     : `APMC_ST_FULLDOWN;
            `APMC_SEL_NORMAL:   idleState = `APMC_ST_UP;
            `APMC_SEL_FULLDOWN: idleState = `APMC_ST_FULLDOWN;
            `APMC_SEL_PARTIAL:  idleState = `APMC_ST_PARTDOWN;
            // Unreachable with two bits; keeps the decode complete
            default:            idleState = `APMC_ST_UP;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   // Both pins are asynchronous to core_clk; each level passes three flops
   // and counts once the last two stages agree
   apmc_pin_sync #(.RESET_LEVEL(1'b1)) sleepSync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .pinIn    (sleepPin_n),
      .pinLevel (sleepLevel)
   );

   // Start pin idles high; the reset level matches, so no false edge
   apmc_pin_sync #(.RESET_LEVEL(1'b1)) startSync (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .pinIn    (conversion_start_n),
      .pinLevel (startLevel)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Shared wake and conversion timer
   // Wake and conversion never overlap, so one timer serves both
   // Twelve bits cover the full wake time with room to spare
   apmc_wait_timer #(.WIDTH(12)) waitTimer (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .load      (timerLoad),
      .loadValue (timerValue),
      .expired   (timerDone)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control register; select bits reset to zero
   // A write to the control offset lands at the APB access edge; other
   // offsets leave these bits alone
   always @(posedge core_clk) begin
      if (sys_rst) begin
         power_select_high <= 1'b0;
         power_select_low  <= 1'b0;
         swStart           <= 1'b0;
         calRequest        <= 1'b0;
      end else begin
         if (wrAccess && paddr == `APMC_CTRL_ADDR) begin
            power_select_high <= pwdata[`APMC_CTRL_SEL_HI];
            power_select_low  <= pwdata[`APMC_CTRL_SEL_LO];
            // Calibration strobe stands for one cycle only
            calRequest        <= pwdata[`APMC_CTRL_CAL];
         end else begin
            // Calibration never changes the select bits itself
            calRequest        <= 1'b0;
         end
         // Start bit clears once powerState is CONVERT, or when the conversion ends; a new write wins
         // A software start waits here until the machine is up
         if (wrAccess && paddr == `APMC_CTRL_ADDR && pwdata[`APMC_CTRL_START]) begin
            swStart <= 1'b1;
         end else if (busyFall || powerState == `APMC_ST_CONVERT) begin
            swStart <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Edge history and result latch in straight binary
   // startPrev resets to the idle high level so reset makes no false edge
   always @(posedge core_clk) begin
      if (sys_rst) begin
         startPrev <= 1'b1;
         result    <= {RES_BITS{1'b0}};
      end else begin
         startPrev <= startLevel;
         // Code taken as the converter hands it over
         if (busyFall) begin
            result <= sampleCode;
         end
      end
   end

   // Conversion ends on the edge at which the timer has run out
   assign busyFall = (powerState == `APMC_ST_CONVERT) && timerDone && !timerLoad;

   ////////////////////////////////////////////////////////////////////////////
   // Power state machine
   //   UP       : powered; a start request converts unless full down is forced, else drop to the idle
   //              state that the select bits and the pin ask for
   //   FULLDOWN : everything off; PARTDOWN keeps the reference alive
   //   WAKING   : wake time after a start fall or a power-up select
   //   CONVERT  : busy high for CONV_CYCLES, then back to the idle state
   // A woken converter waits in UP while the start pin is still low, so the
   // rising edge that starts the conversion is not missed, unless it comes while the state is still WAKING.
   always @* begin
      next_powerState = powerState;
      timerLoad       = 1'b0;
      timerValue      = 12'h000;
      case (powerState)
         `APMC_ST_UP: begin
            // Forced full down takes no conversion
            if (convRequest && powerSelect != `APMC_SEL_FULLDOWN) begin
               next_powerState = `APMC_ST_CONVERT;
               timerLoad       = 1'b1;
               timerValue      = CONV_LAST[11:0];
            end else if ((startLevel || powerSelect == `APMC_SEL_FULLDOWN)
                         && idleState(powerSelect, sleepLevel) != `APMC_ST_UP) begin
               // Drop once no start pulse is pending, or at once when full down is forced
               next_powerState = idleState(powerSelect, sleepLevel);
            end
         end
         `APMC_ST_FULLDOWN, `APMC_ST_PARTDOWN: begin
            // Wake on start pin falling, or when selects ask for power;
            // forced full down ignores the start pin
            if (powerSelect != `APMC_SEL_FULLDOWN
                && (startFall || idleState(powerSelect, sleepLevel) == `APMC_ST_UP)) begin
               next_powerState = `APMC_ST_WAKING;
               timerLoad       = 1'b1;
               timerValue      = WAKE_CYCLES[11:0];
            end else if (idleState(powerSelect, sleepLevel) != powerState) begin
               next_powerState = idleState(powerSelect, sleepLevel);
            end
         end
         `APMC_ST_WAKING: begin
            // Ready after the wake time, then convert or settle
            // The timer was loaded on the edge that entered this state
            if (timerDone) begin
               next_powerState = `APMC_ST_UP;
            end
         end
         `APMC_ST_CONVERT: begin
            // On busy falling drop back to the selected idle state
            // With the pin low or partial selected this powers down again
            if (timerDone) begin
               next_powerState = idleState(powerSelect, sleepLevel);
            end
         end
         default: begin
            // Unused codes recover to powered up
            next_powerState = `APMC_ST_UP;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // State and power outputs
   // Enables follow the next state so they change with powerState
   always @(posedge core_clk) begin
      if (sys_rst) begin
         // Out of reset the converter is fully powered
         powerState      <= `APMC_ST_UP;
         coreEnable      <= 1'b1;
         referenceEnable <= 1'b1;
         busy            <= 1'b0;
      end else begin
         powerState      <= next_powerState;
         // Full down stops everything, partial keeps the reference
         coreEnable      <= (next_powerState != `APMC_ST_FULLDOWN)
                          && (next_powerState != `APMC_ST_PARTDOWN);
         referenceEnable <= (next_powerState != `APMC_ST_FULLDOWN);
         // Busy is high exactly while converting
         busy            <= (next_powerState == `APMC_ST_CONVERT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB read data, registered in the setup cycle
   // Loaded at the setup edge, the data stand through the access edge, so
   // the master takes them with no wait state
   always @(posedge core_clk) begin
      if (sys_rst) begin
         prdata <= 32'h00000000;
      end else if (rdSetup) begin
         if (!known(paddr)) begin
            // Unmapped addresses read zero
            prdata <= 32'h00000000;
         end else begin
            // Status packs state, enables, busy and the synchronised pin
            case (paddr)
               `APMC_CTRL_ADDR:   prdata <= {28'h0000000, calRequest, swStart,
                                             power_select_high, power_select_low};
               `APMC_STATUS_ADDR: prdata <= {25'h0000000, sleepLevel, busy,
                                             referenceEnable, coreEnable, powerState};
               `APMC_RESULT_ADDR: prdata <= {{(32-RES_BITS){1'b0}}, result};
               default:           prdata <= 32'h00000000;
            endcase
         end
      end
   end
endmodule

/* bench/apmc_power_ctrl_assertions.sv */
// Port checks for the converter power-mode controller.
// Assumes one core_clk domain and a synchronous reset; bound below.
`timescale 1ns/1ps
`include "apmc_map.vh"
module apmc_power_ctrl_assertions #(
   parameter WAKE_CYCLES = 200,
   parameter CONV_CYCLES = 20
) (
   input wire        core_clk,
   input wire        sys_rst,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   input wire        coreEnable,
   input wire        referenceEnable,
   input wire        busy,
   input wire [2:0]  powerState
);
   reg [1:0]  selSeen;  // Select bits as last written
   reg [15:0] busyRun;  // Cycles busy has stood
   reg [15:0] wakeRun;  // Cycles spent waking
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   /////////////////////////////////////////////////////////////////////////////
   // Track select writes and run lengths
   always @(posedge core_clk) begin
      if (sys_rst) begin
         selSeen <= 2'h0;
         busyRun <= 16'h0;
         wakeRun <= 16'h0;
      end else begin
         if (psel && penable && pwrite && paddr == `APMC_CTRL_ADDR)
            selSeen <= pwdata[1:0];
         busyRun <= busy ? busyRun + 16'h1 : 16'h0;
         wakeRun <= (powerState == `APMC_ST_WAKING) ? wakeRun + 16'h1 : 16'h0;
      end
   end
   /////////////////////////////////////////////////////////////////////////////
   chk_full_off: assert property (powerState == `APMC_ST_FULLDOWN |->
      !coreEnable && !referenceEnable) else $error("full down left a supply on");
   chk_partial_ref: assert property (powerState == `APMC_ST_PARTDOWN |->
      referenceEnable && !coreEnable) else $error("partial down supplies wrong");
   chk_up_powered: assert property (powerState == `APMC_ST_UP |->
      coreEnable && referenceEnable) else $error("up state not powered");
   chk_reset_state: assert property ($past(sys_rst) |->
      powerState == `APMC_ST_UP && !busy && prdata == 32'h0) else $error("bad reset state");
   chk_busy_length: assert property ($fell(busy) |-> busyRun == CONV_CYCLES)
      else $error("conversion length wrong");
   chk_wake_length: assert property ($past(powerState) == `APMC_ST_WAKING &&
      powerState != `APMC_ST_WAKING |-> wakeRun >= WAKE_CYCLES && wakeRun <= WAKE_CYCLES + 1)
      else $error("wake length wrong");
   chk_normal_sel: assert property ((selSeen == 2'h1) [*3] |->
      powerState != `APMC_ST_FULLDOWN && powerState != `APMC_ST_PARTDOWN)
      else $error("normal mode powered down");
   chk_forced_down: assert property ((selSeen == 2'h2 && !busy) [*3] |->
      powerState == `APMC_ST_FULLDOWN) else $error("forced down not taken");
   chk_unmapped_read: assert property (psel && !penable && !pwrite && paddr > 12'h008
      |=> prdata == 32'h0) else $error("unmapped read not zero");
   chk_zero_wait: assert property (psel && penable |-> pready && !pslverr)
      else $error("bus answer not immediate");
   cov_partial: cover property (powerState == `APMC_ST_PARTDOWN);
   cov_waking: cover property (powerState == `APMC_ST_WAKING);
   cov_convert: cover property ($rose(busy));
endmodule

bind apmc_power_ctrl apmc_power_ctrl_assertions #(.WAKE_CYCLES(WAKE_CYCLES),
   .CONV_CYCLES(CONV_CYCLES)) u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .coreEnable(coreEnable),
   .referenceEnable(referenceEnable), .busy(busy), .powerState(powerState));

/* bench/apmc_host_model.sv */
// Host-side model: power-down pin, start pin and the raw converter code.
// Assumes the bench calls its tasks from the core_clk domain.
`timescale 1ns/1ps
module apmc_host_model (
   input  wire        core_clk,
   output reg         sleepPin_n,
   output reg         conversion_start_n,
   output reg  [13:0] sampleCode
);
   // Pins idle high so software alone picks the power state
   initial begin
      sleepPin_n         = 1'b1;
      conversion_start_n = 1'b1;
      sampleCode         = 14'h3FFF;
   end
   // Power-down pin only moved while select bits are zero
   task set_sleep(input bit level);
      @(posedge core_clk);
      sleepPin_n <= level;
   endtask
   // Fall wakes, rise converts; held low for lowCycles cycles, which callers set past the wake time when waking from down
   task pulse_start(input int lowCycles);
      @(posedge core_clk);
      conversion_start_n <= 1'b0;
      repeat (lowCycles) @(posedge core_clk);
      conversion_start_n <= 1'b1;
   endtask
   // Code offered to the next conversion
   task set_code(input logic [13:0] code);
      @(posedge core_clk);
      sampleCode <= code;
   endtask
endmodule

/* bench/adc_power_mode_control_bench.sv */
// Self-checking bench for the converter power-mode controller.
// Assumes shortened wake and conversion counts set by parameter.
`timescale 1ns/1ps
`include "apmc_map.vh"
module adc_power_mode_control_bench;
   localparam WAKE = 4;  // Shortened wake time
   localparam CONV = 3;  // Shortened conversion time
   reg         core_clk, sys_rst, psel, penable, pwrite;
   reg  [11:0] paddr;
   reg  [31:0] pwdata, rd;
   wire [31:0] prdata;
   wire        pready, pslverr, sleepPin_n, startPin_n, coreEnable, referenceEnable, busy;
   wire [13:0] sampleCode;
   wire [2:0]  powerState;
   integer     nFail, nCompared, cycles, i;
   apmc_power_ctrl #(.WAKE_CYCLES(WAKE), .CONV_CYCLES(CONV)) u_dut (.core_clk(core_clk),
      .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sleepPin_n(sleepPin_n), .conversion_start_n(startPin_n), .sampleCode(sampleCode),
      .coreEnable(coreEnable), .referenceEnable(referenceEnable), .busy(busy),
      .powerState(powerState));
   apmc_host_model u_host (.core_clk(core_clk), .sleepPin_n(sleepPin_n),
      .conversion_start_n(startPin_n), .sampleCode(sampleCode));
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Hang guard
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         nFail = nFail + 1;
         conclude;
      end
   end
   task conclude;
      $display("Compared %0d, failed %0d", nCompared, nFail);
      if (nFail == 0 && nCompared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared = nCompared + 1;
      if (seen !== exp) begin
         nFail = nFail + 1;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One APB transfer; read data lands in rd
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      @(posedge core_clk);
      while (pready !== 1'b1) @(posedge core_clk);
      rd = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task wait_state(input logic [2:0] s);
      for (i = 0; i < WAKE + 30 && powerState !== s; i++) @(negedge core_clk);
      check("powerState", powerState, s);
   endtask
   task wait_busy(input logic lvl);
      for (i = 0; i < 40 && busy !== lvl; i++) @(negedge core_clk);
      check("busy", busy, lvl);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   task t_reset;
      apb(1'b0, `APMC_CTRL_ADDR, 32'h0);   check("ctrl", rd, 32'h0);
      apb(1'b0, `APMC_STATUS_ADDR, 32'h0); check("status", rd, 32'h58);
      apb(1'b0, 12'h00C, 32'h0);           check("unmapped", rd, 32'h0);
   endtask
   task t_pin_high;
      u_host.pulse_start(2);
      wait_busy(1'b1);
      wait_busy(1'b0);
      wait_state(`APMC_ST_UP);
      apb(1'b0, `APMC_RESULT_ADDR, 32'h0); check("result", rd, 32'h3FFF);
   endtask
   task t_pin_low;
      u_host.set_code(14'h0000);
      u_host.set_sleep(1'b0);
      wait_state(`APMC_ST_FULLDOWN);
      check("supplies", {coreEnable, referenceEnable}, 32'h0);
      u_host.pulse_start(WAKE + 8);
      wait_busy(1'b1);
      wait_busy(1'b0);
      wait_state(`APMC_ST_FULLDOWN);
      apb(1'b0, `APMC_RESULT_ADDR, 32'h0); check("result", rd, 32'h0);
      u_host.set_sleep(1'b1);
      wait_state(`APMC_ST_UP);
   endtask
   task t_sel_modes;
      for (int s = 1; s < 4; s++) begin
         apb(1'b1, `APMC_CTRL_ADDR, s);
         wait_state(s == 1 ? `APMC_ST_UP : s == 2 ? `APMC_ST_FULLDOWN : `APMC_ST_PARTDOWN);
         check("core", coreEnable, s == 1);
         check("reference", referenceEnable, s != 2);
         if (s == 2) begin
            u_host.pulse_start(WAKE + 8);
            repeat (8) @(negedge core_clk);
            check("forced down", powerState, `APMC_ST_FULLDOWN);
         end
      end
   endtask
   task t_soft;
      apb(1'b1, `APMC_CTRL_ADDR, 32'h1);
      wait_state(`APMC_ST_UP);
      apb(1'b1, `APMC_CTRL_ADDR, 32'h5);
      wait_busy(1'b1);
      wait_busy(1'b0);
      apb(1'b0, `APMC_CTRL_ADDR, 32'h0); check("start cleared", rd, 32'h1);
      apb(1'b1, `APMC_CTRL_ADDR, 32'h9);
      repeat (6) @(negedge core_clk);
      check("after cal", powerState, `APMC_ST_UP);
      apb(1'b0, `APMC_CTRL_ADDR, 32'h0); check("cal cleared", rd, 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h0; pwdata = 32'h0; nFail = 0; nCompared = 0; cycles = 0;
      repeat (12) @(posedge core_clk);
      sys_rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      t_reset;
      t_pin_high;
      t_pin_low;
      t_sel_modes;
      t_soft;
      conclude;
   end
endmodule
